// *** inc/cmf_consts.svh ***
`ifndef CMF_CONSTS_SVH
`define CMF_CONSTS_SVH

// APB address regions, taken from paddr[11:8].
`define CMF_REGION_GLOBAL 4'h0
`define CMF_REGION_MBX    4'h1
`define CMF_REGION_FILTER 4'h2

// Global registers, by word index paddr[5:2].
`define CMF_G_PAGE 4'h0
`define CMF_G_TPR  4'h1
`define CMF_G_TSR  4'h2
`define CMF_G_MODE 4'h3

// Mailbox word indices, paddr[5:2]; the mailbox number is paddr[7:6].
`define CMF_W_CTRL  4'h0
`define CMF_W_DLC   4'h1
`define CMF_W_ID0   4'h2
`define CMF_W_ID1   4'h3
`define CMF_W_ID2   4'h4
`define CMF_W_ID3   4'h5
`define CMF_W_DATA0 4'h6
`define CMF_W_STLO  4'he
`define CMF_W_STHI  4'hf

// Mailbox control/status and length-register bit positions.
`define CMF_B_TX_ERROR_FLAG 5
`define CMF_B_ARB_LOST_FLAG 4
`define CMF_B_TX_SUCCESS_FLAG 3
`define CMF_B_REQUEST_COMPLETED_FLAG 2
`define CMF_B_ABORT_REQUEST 1
`define CMF_B_TRANSMIT_REQUEST 0
`define CMF_B_TGT  7

// Mode register bit positions.
`define CMF_B_TTM   0
`define CMF_B_IRQEN 1

// Filter configuration layout.
`define CMF_B_FACT_LO 0
`define CMF_B_FACT_HI 4
`define CMF_PAGE_CFG  2
`define CMF_NUM_CFCR  4

// Writable-bit masks; reserved bits read zero.
`define CMF_PAGE_MASK 8'h07
`define CMF_ID0_MASK  8'h7f
`define CMF_ID3_MASK  8'hfe
`define CMF_DLC_MASK  8'h8f
`define CMF_RESET8    8'h00

`endif

// *** inc/cmf_pkg.sv ***
package cmf_pkg;

  typedef enum logic [1:0] {
    CMF_RES_OK    = 2'h0,
    CMF_RES_ARB   = 2'h1,
    CMF_RES_ERR   = 2'h2,
    CMF_RES_ABORT = 2'h3
  } cmf_result_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  mbx;
    cmf_result_t kind;
  } cmf_tx_event_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] mbx;
  } cmf_sof_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] mbx;
    logic [3:0] word;
  } cmf_eng_rd_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  fmi;
    logic [31:0] ident;
    logic [7:0]  dlc;
    logic [63:0] data;
  } cmf_rx_msg_t;

endpackage

// *** hw/cmf_regs.sv ***
// The implementer's own choices: the APB register port and the register addresses.
`include "cmf_consts.svh"

// Overview of operation
// - Page selector 0..3 shows filter pairs, 4..7 shows filter configuration registers.
// - Software writes to the receive mailbox are always rejected.
// - Transmit mailbox accepts software writes, except to control, only while its empty flag is set.
// - Receive mailbox shows filter match index where transmit mailboxes show control.
// - Each attempt updates error flag bit 5; software clears it.
// - Each attempt updates arbitration-lost flag bit 4; software clears it.
// - Success flag bit 3 updated per attempt, mirrored in transmit status.
// - Request-completed bit 2 sets on completion; cleared by write one or request.
// - Clearing request-completed also clears success, arbitration-lost and error flags.
// - Abort bit set by software, ignored unless pending, cleared when empty.
// - Transmit request bit set by software, cleared when mailbox becomes empty.
// - Receive mailbox stores eight-bit index of the matching filter.
// - Identifier byte 0 holds type, frame type, identifier 10:6; bit 7 zero.
// - Identifier byte 1 holds identifier 5:0 and extended bits 17:16.
// - Identifier bytes 2 and 3 hold extended bits 15:8 and 6:0.
// - Length register protected while not empty; bits 6:4 read zero.
// - In time-triggered mode the global-time bit sends stamp as last bytes.
// - Four-bit length code gives number of data bytes.
// - Eight data bytes per mailbox, protected while mailbox not empty.
// - Start of frame captures sixteen-bit timer into stamp low and high.
// - Per-filter FIFO assignment bit selects receive FIFO 0 or 1.
// - Activation bit enables filter; bank registers change only while inactive.
// - Each configuration register packs two filters: assign, scale, activate fields.
// - With empty-interrupt enable set, completion flags raise the interrupt.
module cmf_regs #(
  parameter int NUM_TX = 3
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire cmf_pkg::cmf_tx_event_t tx_event,
  input  wire cmf_pkg::cmf_sof_t     sof_event,
  input  wire logic [15:0]           timer_value,
  input  wire cmf_pkg::cmf_rx_msg_t  rx_msg,
  input  wire cmf_pkg::cmf_eng_rd_t  eng_rd,
  output logic      [7:0]            eng_rd_data,
  output logic      [NUM_TX-1:0]     tx_pending,
  output logic      [NUM_TX-1:0]     tx_abort,
  output logic                       time_triggered_mode,
  output logic      [31:0]           filter_cfg,
  output logic                       tx_irq
);
  import cmf_pkg::*;

  localparam int NUM_MBX = NUM_TX + 1;
  localparam int RXI     = NUM_TX;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  logic        wr_fire;
  logic [3:0]  region;
  logic [1:0]  wr_mbx;
  logic [3:0]  wr_word;
  logic [7:0]  wr_byte;
  logic        mbx_mapped;

  assign wr_fire    = psel & penable & pready & pwrite;
  assign region     = paddr[11:8];
  assign wr_mbx     = paddr[7:6];
  assign wr_word    = paddr[5:2];
  assign wr_byte    = pwdata[7:0];
  assign mbx_mapped = (int'(wr_mbx) < NUM_MBX);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [7:0]              filter_page_sel_reg;
  logic                    irq_en_reg;
  logic [7:0]              rx_fmi_reg;
  logic [NUM_TX-1:0]       transmit_request_reg;
  logic [NUM_TX-1:0]       abort_request_reg;
  logic [NUM_TX-1:0]       request_completed_flag_reg;
  logic [NUM_TX-1:0]       tx_success_flag_reg;
  logic [NUM_TX-1:0]       arb_lost_flag_reg;
  logic [NUM_TX-1:0]       tx_error_flag_reg;
  logic [`CMF_NUM_CFCR-1:0][7:0] cfcr_reg;
  logic [7:0]              mbx_mem [NUM_MBX][16];
  logic [7:0]              flt_mem [64];
  logic [3:0]              transmit_request_all;
  logic [3:0]              abort_request_all;
  logic [3:0]              request_completed_flag_all;
  logic [3:0]              tx_success_flag_all;
  logic [3:0]              arb_lost_flag_all;
  logic [3:0]              tx_error_flag_all;

  assign transmit_request_all = 4'(transmit_request_reg);
  assign abort_request_all = 4'(abort_request_reg);
  assign request_completed_flag_all = 4'(request_completed_flag_reg);
  assign tx_success_flag_all = 4'(tx_success_flag_reg);
  assign arb_lost_flag_all = 4'(arb_lost_flag_reg);
  assign tx_error_flag_all = 4'(tx_error_flag_reg);

  // ------------------------------------------------------------------
  // APB handshake: one wait state, answer registered
  // ------------------------------------------------------------------
  logic [7:0] rd_next;
  logic       err_next;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & err_next;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= {24'h00_0000, rd_next};
      end
    end
  end

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  always_comb begin
    rd_next  = `CMF_RESET8;
    err_next = 1'b0;
    case (region)
      `CMF_REGION_GLOBAL: begin
        case (wr_word)
          `CMF_G_PAGE: rd_next = filter_page_sel_reg;
          `CMF_G_TPR:  rd_next = {4'h0, ~transmit_request_all & 4'(~NUM_TX'(0))};
          `CMF_G_TSR:  rd_next = {tx_success_flag_all, request_completed_flag_all};
          `CMF_G_MODE: rd_next = {6'h00, irq_en_reg, time_triggered_mode};
          default:     err_next = 1'b1;
        endcase
      end
      `CMF_REGION_MBX: begin
        if (!mbx_mapped) begin
          err_next = 1'b1;
        end else if (wr_word == `CMF_W_CTRL) begin
          if (int'(wr_mbx) == RXI) begin
            rd_next = rx_fmi_reg;
          end else begin
            rd_next = {2'b00, tx_error_flag_all[wr_mbx], arb_lost_flag_all[wr_mbx], tx_success_flag_all[wr_mbx],
                       request_completed_flag_all[wr_mbx], abort_request_all[wr_mbx], transmit_request_all[wr_mbx]};
          end
        end else begin
          rd_next = mbx_mem[wr_mbx][wr_word];
        end
      end
      `CMF_REGION_FILTER: begin
        if (filter_page_sel_reg[`CMF_PAGE_CFG]) begin
          rd_next = (wr_word < 4'(`CMF_NUM_CFCR)) ? cfcr_reg[wr_word[1:0]] : `CMF_RESET8;
        end else begin
          rd_next = flt_mem[{filter_page_sel_reg[1:0], wr_word}];
        end
      end
      default: err_next = 1'b1;
    endcase
  end

  // ------------------------------------------------------------------
  // Global registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_page_sel_reg <= `CMF_RESET8;
      time_triggered_mode <= 1'b0;
      irq_en_reg          <= 1'b0;
    end else if (wr_fire && region == `CMF_REGION_GLOBAL) begin
      if (wr_word == `CMF_G_PAGE) begin
        filter_page_sel_reg <= wr_byte & `CMF_PAGE_MASK;
      end
      if (wr_word == `CMF_G_MODE) begin
        time_triggered_mode <= wr_byte[`CMF_B_TTM];
        irq_en_reg          <= wr_byte[`CMF_B_IRQEN];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= irq_en_reg & (|request_completed_flag_reg);
    end
  end

  // ------------------------------------------------------------------
  // Transmit mailbox control/status, one copy per mailbox
  // ------------------------------------------------------------------
  genvar m;
  generate
    for (m = 0; m < NUM_TX; m++) begin : g_tx
      logic ctrl_wr;
      logic ev;
      logic done;
      logic new_req;
      logic sw_clr;

      assign ctrl_wr = wr_fire && region == `CMF_REGION_MBX && int'(wr_mbx) == m
                       && wr_word == `CMF_W_CTRL;
      assign ev      = tx_event.valid && int'(tx_event.mbx) == m;
      assign done    = ev && (tx_event.kind == CMF_RES_OK || tx_event.kind == CMF_RES_ABORT);
      assign new_req = ctrl_wr && wr_byte[`CMF_B_TRANSMIT_REQUEST] && !transmit_request_reg[m];
      assign sw_clr  = (ctrl_wr && wr_byte[`CMF_B_REQUEST_COMPLETED_FLAG]) || new_req;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          transmit_request_reg[m] <= 1'b0;
        end else if (done) begin
          transmit_request_reg[m] <= 1'b0;
        end else if (new_req) begin
          transmit_request_reg[m] <= 1'b1;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          abort_request_reg[m] <= 1'b0;
        end else if (done) begin
          abort_request_reg[m] <= 1'b0;
        end else if (ctrl_wr && wr_byte[`CMF_B_ABORT_REQUEST] && transmit_request_reg[m]) begin
          abort_request_reg[m] <= 1'b1;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          request_completed_flag_reg[m] <= 1'b0;
        end else if (done) begin
          request_completed_flag_reg[m] <= 1'b1;
        end else if (sw_clr) begin
          request_completed_flag_reg[m] <= 1'b0;
        end
      end

      // attempt result, cleared with completion flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_success_flag_reg[m] <= 1'b0;
          arb_lost_flag_reg[m] <= 1'b0;
          tx_error_flag_reg[m] <= 1'b0;
        end else if (ev && tx_event.kind != CMF_RES_ABORT) begin
          tx_success_flag_reg[m] <= (tx_event.kind == CMF_RES_OK);
          arb_lost_flag_reg[m] <= (tx_event.kind == CMF_RES_ARB);
          tx_error_flag_reg[m] <= (tx_event.kind == CMF_RES_ERR);
        end else if (sw_clr && !done) begin
          tx_success_flag_reg[m] <= 1'b0;
          arb_lost_flag_reg[m] <= 1'b0;
          tx_error_flag_reg[m] <= 1'b0;
        end
      end
    end
  endgenerate

  assign tx_pending = transmit_request_reg;
  assign tx_abort   = abort_request_reg;

  // ------------------------------------------------------------------
  // Mailbox storage
  // ------------------------------------------------------------------
  logic mem_wr_ok;

  assign mem_wr_ok = wr_fire && region == `CMF_REGION_MBX && wr_word != `CMF_W_CTRL
                     && int'(wr_mbx) < NUM_TX && !transmit_request_all[wr_mbx];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fmi_reg <= `CMF_RESET8;
    end else if (rx_msg.valid) begin
      rx_fmi_reg <= rx_msg.fmi;
    end
  end

  always_ff @(posedge pclk) begin
    if (rx_msg.valid) begin
      mbx_mem[RXI][`CMF_W_DLC] <= rx_msg.dlc & `CMF_DLC_MASK;
      mbx_mem[RXI][`CMF_W_ID0] <= rx_msg.ident[31:24] & `CMF_ID0_MASK;
      mbx_mem[RXI][`CMF_W_ID1] <= rx_msg.ident[23:16];
      mbx_mem[RXI][`CMF_W_ID2] <= rx_msg.ident[15:8];
      mbx_mem[RXI][`CMF_W_ID3] <= rx_msg.ident[7:0] & `CMF_ID3_MASK;
      for (int k = 0; k < 8; k++) begin
        mbx_mem[RXI][4'(`CMF_W_DATA0 + k)] <= rx_msg.data[8*k +: 8];
      end
    end
    if (mem_wr_ok) begin
      case (wr_word)
        `CMF_W_DLC: mbx_mem[wr_mbx][wr_word] <= wr_byte & `CMF_DLC_MASK;
        `CMF_W_ID0: mbx_mem[wr_mbx][wr_word] <= wr_byte & `CMF_ID0_MASK;
        `CMF_W_ID3: mbx_mem[wr_mbx][wr_word] <= wr_byte & `CMF_ID3_MASK;
        default:    mbx_mem[wr_mbx][wr_word] <= wr_byte;
      endcase
    end
    // stamp capture at start of frame
    if (sof_event.valid && int'(sof_event.mbx) < NUM_MBX) begin
      mbx_mem[sof_event.mbx][`CMF_W_STLO] <= timer_value[7:0];
      mbx_mem[sof_event.mbx][`CMF_W_STHI] <= timer_value[15:8];
    end
  end

  // ------------------------------------------------------------------
  // Engine read port
  // ------------------------------------------------------------------
  logic [7:0] eng_next;
  logic [3:0] eng_dlc;
  logic [3:0] eng_idx;
  logic       eng_tgt;

  always_comb begin
    eng_dlc  = mbx_mem[eng_rd.mbx][`CMF_W_DLC][3:0];
    eng_tgt  = mbx_mem[eng_rd.mbx][`CMF_W_DLC][`CMF_B_TGT] & time_triggered_mode;
    eng_idx  = eng_rd.word - `CMF_W_DATA0;
    eng_next = mbx_mem[eng_rd.mbx][eng_rd.word];
    // stamp replaces the last two data bytes
    if (eng_tgt && eng_rd.word >= `CMF_W_DATA0 && eng_rd.word < `CMF_W_STLO
        && eng_dlc >= 4'h2) begin
      if (eng_idx == eng_dlc - 4'h2) begin
        eng_next = mbx_mem[eng_rd.mbx][`CMF_W_STLO];
      end else if (eng_idx == eng_dlc - 4'h1) begin
        eng_next = mbx_mem[eng_rd.mbx][`CMF_W_STHI];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_rd_data <= `CMF_RESET8;
    end else if (eng_rd.valid && int'(eng_rd.mbx) < NUM_MBX) begin
      eng_rd_data <= eng_next;
    end
  end

  // ------------------------------------------------------------------
  // Filter configuration and banks
  // ------------------------------------------------------------------
  logic [2:0] flt_idx;
  logic       flt_active;

  assign flt_idx    = {filter_page_sel_reg[1:0], wr_word[3]};
  assign flt_active = flt_idx[0] ? cfcr_reg[flt_idx[2:1]][`CMF_B_FACT_HI]
                                 : cfcr_reg[flt_idx[2:1]][`CMF_B_FACT_LO];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfcr_reg <= '0;
    end else if (wr_fire && region == `CMF_REGION_FILTER
                 && filter_page_sel_reg[`CMF_PAGE_CFG]
                 && wr_word < 4'(`CMF_NUM_CFCR)) begin
      cfcr_reg[wr_word[1:0]] <= wr_byte;
    end
  end

  assign filter_cfg = cfcr_reg;

  always_ff @(posedge pclk) begin
    if (wr_fire && region == `CMF_REGION_FILTER
        && !filter_page_sel_reg[`CMF_PAGE_CFG] && !flt_active) begin
      flt_mem[{filter_page_sel_reg[1:0], wr_word}] <= wr_byte;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_page_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && region == `CMF_REGION_GLOBAL && wr_word == `CMF_G_PAGE)
      |=> filter_page_sel_reg == ($past(pwdata[7:0]) & `CMF_PAGE_MASK);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page select not stored");

  property p_tx_protect;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && region == `CMF_REGION_MBX && int'(wr_mbx) < NUM_TX
     && wr_word == `CMF_W_DATA0 && transmit_request_all[wr_mbx])
      |=> mbx_mem[$past(wr_mbx)][`CMF_W_DATA0] == $past(mbx_mem[wr_mbx][`CMF_W_DATA0]);
  endproperty
  a_tx_protect: assert property (p_tx_protect) else $error("pending mailbox written");

  property p_rx_protect;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && region == `CMF_REGION_MBX && int'(wr_mbx) == RXI
     && wr_word == `CMF_W_DATA0 && !rx_msg.valid)
      |=> mbx_mem[RXI][`CMF_W_DATA0] == $past(mbx_mem[RXI][`CMF_W_DATA0]);
  endproperty
  a_rx_protect: assert property (p_rx_protect) else $error("receive mailbox written");

  property p_done_sets;
    @(posedge pclk) disable iff (!presetn)
    (tx_event.valid && tx_event.mbx == 2'h0 && tx_event.kind == CMF_RES_OK)
      |=> request_completed_flag_reg[0] && !transmit_request_reg[0] && tx_success_flag_reg[0] ##1 (request_completed_flag_reg[0] || $past(g_tx[0].sw_clr));
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("completion not recorded");

  property p_abort_ignored;
    @(posedge pclk) disable iff (!presetn)
    (g_tx[0].ctrl_wr && pwdata[`CMF_B_ABORT_REQUEST] && !transmit_request_reg[0]) |=> !abort_request_reg[0];
  endproperty
  a_abort_ignored: assert property (p_abort_ignored) else $error("abort took effect idle");

  property p_req_clears;
    @(posedge pclk) disable iff (!presetn)
    (transmit_request_reg[0] && tx_event.valid && tx_event.mbx == 2'h0
     && tx_event.kind == CMF_RES_ABORT) |=> !transmit_request_reg[0] && !abort_request_reg[0];
  endproperty
  a_req_clears: assert property (p_req_clears) else $error("request not cleared");

  property p_clear_all;
    @(posedge pclk) disable iff (!presetn)
    (g_tx[0].sw_clr && !(tx_event.valid && tx_event.mbx == 2'h0))
      |=> !request_completed_flag_reg[0] && !tx_success_flag_reg[0] && !arb_lost_flag_reg[0] && !tx_error_flag_reg[0];
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("status not cleared");

  property p_arb_lost;
    @(posedge pclk) disable iff (!presetn)
    (tx_event.valid && tx_event.mbx == 2'h0 && tx_event.kind == CMF_RES_ARB)
      |=> arb_lost_flag_reg[0] && !tx_success_flag_reg[0] && !tx_error_flag_reg[0] && transmit_request_reg[0] == $past(transmit_request_reg[0]);
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("arbitration loss not flagged");

  property p_bus_error;
    @(posedge pclk) disable iff (!presetn)
    (tx_event.valid && tx_event.mbx == 2'h0 && tx_event.kind == CMF_RES_ERR)
      |=> tx_error_flag_reg[0] && !arb_lost_flag_reg[0] && !tx_success_flag_reg[0];
  endproperty
  a_bus_error: assert property (p_bus_error) else $error("bus error not flagged");

  property p_stamp;
    @(posedge pclk) disable iff (!presetn)
    (sof_event.valid && sof_event.mbx == 2'h0)
      |=> {mbx_mem[0][`CMF_W_STHI], mbx_mem[0][`CMF_W_STLO]} == $past(timer_value);
  endproperty
  a_stamp: assert property (p_stamp) else $error("time stamp not captured");

endmodule

// *** tb/cmf_engine_model.sv ***
module cmf_engine_model (
  input  wire logic                   pclk,
  output cmf_pkg::cmf_tx_event_t      tx_event,
  output cmf_pkg::cmf_sof_t           sof_event,
  output logic [15:0]                 timer_value,
  output cmf_pkg::cmf_rx_msg_t        rx_msg,
  output cmf_pkg::cmf_eng_rd_t        eng_rd,
  input  wire logic [7:0]             eng_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmf_pkg::*;
  logic [15:0] tick = 16'h0000;
  initial begin
    tx_event = '0;
    sof_event = '0;
    rx_msg = '0;
    eng_rd = '0;
  end
  // The timer runs free so that a stale capture cannot pass.
  always @(posedge pclk) tick <= tick + 16'h0001;
  assign timer_value = tick;
  task automatic result(input logic [1:0] m, input cmf_result_t k);
    tx_event <= '{1'b1, m, k};
    @(posedge pclk);
    tx_event <= '0;
    @(posedge pclk);
  endtask
  task automatic sof(input logic [1:0] m, output logic [15:0] s);
    sof_event <= '{1'b1, m};
    @(posedge pclk);
    s = timer_value;
    sof_event <= '0;
    @(posedge pclk);
  endtask
  task automatic rx(input logic [7:0] f, input logic [31:0] id, input logic [63:0] d);
    rx_msg <= '{1'b1, f, id, 8'h08, d};
    @(posedge pclk);
    rx_msg <= '0;
    @(posedge pclk);
  endtask
  task automatic fetch(input logic [1:0] m, input logic [3:0] w, output logic [7:0] d);
    eng_rd <= '{1'b1, m, w};
    @(posedge pclk);
    eng_rd <= '0;
    @(posedge pclk);
    d = eng_rd_data;
  endtask
endmodule

// *** tb/can_mailbox_filter_regs_tb.sv ***
`include "cmf_consts.svh"
module can_mailbox_filter_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cmf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, filter_cfg;
  logic pready, pslverr, ttm, tx_irq, serr;
  logic [2:0] tx_pending, tx_abort;
  logic [7:0] eng_rd_data, r, d;
  logic [15:0] timer_value, s;
  cmf_tx_event_t tx_event;
  cmf_sof_t sof_event;
  cmf_rx_msg_t rx_msg;
  cmf_eng_rd_t eng_rd;
  int err_total = 0, total_checks = 0, cycles = 0;
  logic [3:0] wl [5] = '{`CMF_W_ID0, `CMF_W_ID1, `CMF_W_ID2, `CMF_W_ID3, `CMF_W_DLC};
  logic [7:0] ex [5] = '{8'h7f, 8'hff, 8'hff, 8'hfe, 8'h8f};
  always #2 pclk = ~pclk;
  cmf_regs #(.NUM_TX(3)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_event(tx_event), .sof_event(sof_event),
    .timer_value(timer_value), .rx_msg(rx_msg), .eng_rd(eng_rd), .eng_rd_data(eng_rd_data),
    .tx_pending(tx_pending), .tx_abort(tx_abort), .time_triggered_mode(ttm),
    .filter_cfg(filter_cfg), .tx_irq(tx_irq));
  cmf_engine_model eng (.pclk(pclk), .tx_event(tx_event), .sof_event(sof_event),
    .timer_value(timer_value), .rx_msg(rx_msg), .eng_rd(eng_rd), .eng_rd_data(eng_rd_data));
  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata[7:0];
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(r, exp);
  endtask
  function automatic logic [11:0] mb(input int m, input logic [3:0] w);
    return 12'(32'h100 + 64 * m + 4 * w);
  endfunction
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 8'h00);
    rd(mb(0, `CMF_W_CTRL), 8'h00);
    rd(mb(3, `CMF_W_CTRL), 8'h00);
    apb(1'b0, 12'h004, 8'h00);
    chk(r & 8'h07, 8'h07);
    wr(12'h000, 8'hff);
    rd(12'h000, 8'h07);
    for (int i = 0; i < 5; i++) begin
      wr(mb(0, wl[i]), 8'hff);
      rd(mb(0, wl[i]), ex[i]);
    end
    wr(mb(0, `CMF_W_DATA0), 8'h5a);
    wr(mb(0, `CMF_W_CTRL), 8'h01);
    chk_bit(tx_pending[0], 1'b1);
    apb(1'b0, 12'h004, 8'h00);
    chk(r & 8'h07, 8'h06);
    wr(mb(0, `CMF_W_DLC), 8'h03);
    rd(mb(0, `CMF_W_DLC), 8'h8f);
    wr(mb(0, `CMF_W_DATA0), 8'h00);
    rd(mb(0, `CMF_W_DATA0), 8'h5a);
    eng.result(2'd0, CMF_RES_ARB);
    rd(mb(0, `CMF_W_CTRL), 8'h11);
    eng.result(2'd0, CMF_RES_ERR);
    rd(mb(0, `CMF_W_CTRL), 8'h21);
    eng.result(2'd0, CMF_RES_OK);
    rd(mb(0, `CMF_W_CTRL), 8'h0c);
    rd(12'h008, 8'h11);
    chk_bit(tx_irq, 1'b0);
    wr(12'h00c, 8'h02);
    rd(12'h00c, 8'h02);
    chk_bit(tx_irq, 1'b1);
    wr(mb(0, `CMF_W_CTRL), 8'h04);
    rd(mb(0, `CMF_W_CTRL), 8'h00);
    rd(12'h008, 8'h00);
    chk_bit(tx_irq, 1'b0);
    // abort without and with a pending request
    wr(mb(0, `CMF_W_CTRL), 8'h02);
    rd(mb(0, `CMF_W_CTRL), 8'h00);
    wr(mb(0, `CMF_W_CTRL), 8'h01);
    wr(mb(0, `CMF_W_CTRL), 8'h02);
    rd(mb(0, `CMF_W_CTRL), 8'h03);
    chk_bit(tx_abort[0], 1'b1);
    eng.result(2'd0, CMF_RES_ABORT);
    rd(mb(0, `CMF_W_CTRL), 8'h04);
    eng.rx(8'h5a, 32'h12345678, 64'h0807060504030201);
    rd(mb(3, `CMF_W_CTRL), 8'h5a);
    wr(mb(3, `CMF_W_ID0), 8'h00);
    rd(mb(3, `CMF_W_ID0), 8'h12);
    rd(mb(3, `CMF_W_ID1), 8'h34);
    rd(mb(3, `CMF_W_DLC), 8'h08);
    wr(mb(3, `CMF_W_DATA0), 8'h00);
    rd(mb(3, `CMF_W_DATA0), 8'h01);
    eng.sof(2'd2, s);
    rd(mb(2, `CMF_W_STLO), s[7:0]);
    rd(mb(2, `CMF_W_STHI), s[15:8]);
    wr(mb(0, `CMF_W_DLC), 8'h82);
    eng.sof(2'd0, s);
    eng.fetch(2'd0, `CMF_W_DATA0, d);
    chk(d, 8'h5a);
    wr(12'h00c, 8'h01);
    chk_bit(ttm, 1'b1);
    eng.fetch(2'd0, `CMF_W_DATA0, d);
    chk(d, s[7:0]);
    eng.fetch(2'd0, 4'h7, d);
    chk(d, s[15:8]);
    // bank writes with filters idle and active, and configuration set up
    wr(12'h000, 8'h00);
    wr(12'h220, 8'h44);
    wr(12'h000, 8'h04);
    wr(12'h200, 8'hf0);
    chk(filter_cfg[7:0], 8'hf0);
    rd(12'h200, 8'hf0);
    wr(12'h000, 8'h00);
    wr(12'h220, 8'h99);
    rd(12'h220, 8'h44);
    wr(12'h200, 8'h33);
    rd(12'h200, 8'h33);
    wr(12'h000, 8'h01);
    wr(12'h200, 8'h77);
    wr(12'h000, 8'h00);
    rd(12'h200, 8'h33);
    apb(1'b0, 12'h300, 8'h00);
    chk_bit(serr, 1'b1);
    stop_test();
  end
endmodule
